// ==== hw/fptr_pkg.sv ====
// Constants, address map and byte image of the flash parameter table store
// What this block does
// - Latency table offsets 27h to 2Bh read FFh, last row fields unsupported.
// - Padding parameter reads ID F0h, length 0Fh, then FFh through offset 10h.
// - Discovery parameter reads ID A5h, length 50h, payload from offset 02h.
// - Offset 02h is basic parameter 00h, also readable at space address 1120h.
// - First basic byte reads E7h with fixed status, buffer and erase fields.
// - Second basic byte at offset 03h reads FFh, no 4-kB erase opcode.
// - Third basic byte reads EAh: quad reads, DDR, address code 01b.
// - Offset 05h reads FFh; 06h to 09h read FFh FFh FFh 3Fh density.
// - Latency rows open with frequency limit byte, then code, then cycle counts.
package fptr_pkg;

    typedef enum logic [1:0] {
        FPTR_SPACE_LAT = 2'b00,
        FPTR_SPACE_PAD = 2'b01,
        FPTR_SPACE_JEDEC = 2'b10,
        FPTR_SPACE_SFDP = 2'b11
    } fptr_space_t;

    localparam int FPTR_DEPTH = 32;
    localparam int FPTR_IDX_W = 6;

    // ==========================================================
    // Offsets
    localparam logic [7:0] FPTR_LAT_FIRST = 8'h27;
    localparam logic [7:0] FPTR_LAT_LAST = 8'h2b;
    localparam logic [7:0] FPTR_LAT_ROW_BASE = 8'h04;
    localparam logic [2:0] FPTR_LAT_FIELD_FREQ = 3'h0;
    localparam logic [2:0] FPTR_LAT_FIELD_CODE = 3'h1;
    localparam logic [7:0] FPTR_OFF_ID = 8'h00;
    localparam logic [7:0] FPTR_OFF_LEN = 8'h01;
    localparam logic [7:0] FPTR_OFF_FILL = 8'h02;
    localparam logic [7:0] FPTR_OFF_BASIC0 = 8'h02;
    localparam logic [7:0] FPTR_OFF_BASIC1 = 8'h03;
    localparam logic [7:0] FPTR_OFF_BASIC2 = 8'h04;
    localparam logic [7:0] FPTR_OFF_DENS_HI = 8'h09;
    localparam logic [7:0] FPTR_JEDEC_LAST = 8'h09;
    localparam logic [15:0] FPTR_SFDP_BASE = 16'h1120;
    localparam logic [15:0] FPTR_SFDP_SPAN = 16'h0007;

    // ==========================================================
    // Byte values
    localparam logic [7:0] FPTR_UNSUP = 8'hff;
    localparam logic [7:0] FPTR_PAD_ID = 8'hf0;
    localparam logic [7:0] FPTR_PAD_LEN = 8'h0f;
    // Last padding byte sits at length location plus length
    localparam logic [7:0] FPTR_PAD_LAST = FPTR_OFF_LEN + FPTR_PAD_LEN;
    localparam logic [7:0] FPTR_SFDP_ID = 8'ha5;
    localparam logic [7:0] FPTR_SFDP_LEN = 8'h50;
    localparam logic [7:0] FPTR_DW1_B0 = 8'he7;
    localparam logic [7:0] FPTR_DW1_B2 = 8'hea;
    localparam logic [7:0] FPTR_DENS_HI = 8'h3f;

    // ==========================================================
    // Image index bases
    localparam logic [5:0] FPTR_IDX_LAT = 6'h00;
    localparam logic [5:0] FPTR_IDX_PAD = 6'h05;
    localparam logic [5:0] FPTR_IDX_JEDEC = 6'h16;
    localparam logic [5:0] FPTR_IDX_MISS = 6'h20;

    localparam logic [7:0] FPTR_IMAGE [0:FPTR_DEPTH-1] = '{
        FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP,
        FPTR_PAD_ID, FPTR_PAD_LEN,
        FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP,
        FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP,
        FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP,
        FPTR_SFDP_ID, FPTR_SFDP_LEN, FPTR_DW1_B0, FPTR_UNSUP, FPTR_DW1_B2,
        FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_UNSUP, FPTR_DENS_HI
    };

endpackage

// ==== hw/fptr_rom.sv ====
// Constant byte image with registered read data
module fptr_rom (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic rd_en,
    input wire logic [fptr_pkg::FPTR_IDX_W-1:0] rd_idx,
    output logic [7:0] rd_data
);
    import fptr_pkg::*;

    logic [7:0] rd_data_reg;
    logic [7:0] rd_data_next;
    logic idx_in_range;

    assign idx_in_range = (rd_idx < FPTR_IDX_MISS);
    // Out of range index reads as unsupported
    assign rd_data_next = idx_in_range ? FPTR_IMAGE[rd_idx[4:0]] : FPTR_UNSUP;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rd_data_reg <= FPTR_UNSUP;
        end else if (rd_en) begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;
endmodule

// ==== hw/fptr_top.sv ====
// Flash parameter table store: address decode, response and checks
module fptr_top (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic req_valid,
    input wire fptr_pkg::fptr_space_t req_space,
    input wire logic [15:0] req_addr,
    output logic rsp_valid,
    output logic rsp_hit,
    output logic [7:0] rsp_data
);
    import fptr_pkg::*;

    // ==========================================================
    // Address decode
    logic [7:0] off8;
    logic hi_zero;
    logic [7:0] lat_rel;
    logic [7:0] lat_row_rel;
    logic [2:0] lat_field;
    logic [15:0] sfdp_delta;
    logic lat_hit;
    logic pad_hit;
    logic jed_hit;
    logic sfdp_hit;
    logic any_hit;
    logic [5:0] lat_idx;
    logic [5:0] pad_idx;
    logic [5:0] jed_idx;
    logic [5:0] sfdp_idx;
    logic [5:0] rom_idx;

    assign off8 = req_addr[7:0];
    assign hi_zero = (req_addr[15:8] == 8'h00);
    assign lat_rel = off8 - FPTR_LAT_FIRST;
    // Row position: frequency limit at field 0, code at field 1, cycle counts after
    assign lat_row_rel = off8 - FPTR_LAT_ROW_BASE;
    assign lat_field = lat_row_rel[2:0];
    assign lat_hit = (req_space == FPTR_SPACE_LAT) && hi_zero && (off8 >= FPTR_LAT_FIRST)
                     && (off8 <= FPTR_LAT_LAST) && (lat_field != FPTR_LAT_FIELD_FREQ)
                     && (lat_field != FPTR_LAT_FIELD_CODE);
    assign pad_hit = (req_space == FPTR_SPACE_PAD) && hi_zero && (off8 <= FPTR_PAD_LAST);
    assign jed_hit = (req_space == FPTR_SPACE_JEDEC) && hi_zero && (off8 <= FPTR_JEDEC_LAST);
    assign sfdp_delta = req_addr - FPTR_SFDP_BASE;
    assign sfdp_hit = (req_space == FPTR_SPACE_SFDP) && (req_addr >= FPTR_SFDP_BASE)
                      && (sfdp_delta <= FPTR_SFDP_SPAN);
    assign any_hit = lat_hit || pad_hit || jed_hit || sfdp_hit;

    assign lat_idx = FPTR_IDX_LAT + lat_rel[5:0];
    assign pad_idx = FPTR_IDX_PAD + off8[5:0];
    assign jed_idx = FPTR_IDX_JEDEC + off8[5:0];
    // Space address 1120h lands on parameter offset 02h
    assign sfdp_idx = FPTR_IDX_JEDEC + FPTR_OFF_BASIC0[5:0] + sfdp_delta[5:0];

    assign rom_idx = lat_hit ? lat_idx :
                     pad_hit ? pad_idx :
                     jed_hit ? jed_idx :
                     sfdp_hit ? sfdp_idx : FPTR_IDX_MISS;

    // ==========================================================
    // Image and response
    logic rsp_valid_reg;
    logic rsp_hit_reg;

    fptr_rom u_rom (
        .clock(clock),
        .reset_n(reset_n),
        .rd_en(req_valid),
        .rd_idx(rom_idx),
        .rd_data(rsp_data)
    );

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid_reg <= 1'b0;
            rsp_hit_reg <= 1'b0;
        end else begin
            rsp_valid_reg <= req_valid;
            rsp_hit_reg <= req_valid && any_hit;
        end
    end

    assign rsp_valid = rsp_valid_reg;
    assign rsp_hit = rsp_hit_reg;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!reset_n);

    lat_tail_a: assert property (req_valid && lat_hit |=> rsp_valid && rsp_hit && rsp_data == 8'hff)
        else $error("latency tail byte not FFh");
    pad_head_a: assert property (req_valid && req_space == FPTR_SPACE_PAD && req_addr == 16'h0000
        |=> rsp_data == 8'hf0 && rsp_hit)
        else $error("padding id wrong");
    pad_fill_a: assert property (req_valid && req_space == FPTR_SPACE_PAD && req_addr >= 16'h0002
        && req_addr <= 16'h0010 |=> rsp_data == 8'hff && rsp_hit)
        else $error("padding fill wrong");
    pad_len_a: assert property (req_valid && req_space == FPTR_SPACE_PAD && req_addr == 16'h0001
        |=> rsp_data == 8'h0f ##1 ($past(req_valid) || $stable(rsp_data)))
        else $error("padding length wrong");
    sfdp_head_a: assert property (req_valid && req_space == FPTR_SPACE_JEDEC && req_addr[15:1] == 15'h0000
        |=> rsp_data == (($past(req_addr[0])) ? 8'h50 : 8'ha5))
        else $error("discovery header wrong");
    sfdp_alias_a: assert property (req_valid && req_space == FPTR_SPACE_SFDP && req_addr == 16'h1120
        |=> rsp_hit && rsp_data == 8'he7 && rsp_data[1:0] == 2'b11 && rsp_data[4:3] == 2'b00)
        else $error("space alias not first basic byte");
    dw1_bytes_a: assert property (req_valid && req_space == FPTR_SPACE_JEDEC && req_addr == 16'h0003
        |=> rsp_data == 8'hff)
        else $error("second basic byte wrong");
    dw1_modes_a: assert property (req_valid && req_space == FPTR_SPACE_JEDEC && req_addr == 16'h0004
        |=> rsp_data == 8'hea && !rsp_data[4] && !rsp_data[0] && rsp_data[2:1] == 2'b01)
        else $error("third basic byte wrong");
    dw1_first_a: assert property (req_valid && req_space == FPTR_SPACE_JEDEC && req_addr == 16'h0002
        |=> rsp_data[7:5] == 3'b111 && rsp_data[2] && rsp_data == 8'he7)
        else $error("first basic byte wrong");
    density_a: assert property (req_valid && req_space == FPTR_SPACE_JEDEC && req_addr >= 16'h0005
        && req_addr <= 16'h0009 |=> rsp_data == (($past(req_addr) == 16'h0009) ? 8'h3f : 8'hff))
        else $error("density bytes wrong");
    miss_value_a: assert property (req_valid && !any_hit |=> !rsp_hit && rsp_data == 8'hff)
        else $error("unmapped read not FFh");
    idle_hold_a: assert property (!req_valid |=> !rsp_valid && $stable(rsp_data))
        else $error("idle cycle disturbed response");
endmodule

// ==== sim/fptr_host.sv ====
// Host reader model issuing byte reads of the parameter store
module fptr_host
(
    input wire logic clock,
    input wire logic rsp_valid,
    input wire logic rsp_hit,
    input wire logic [7:0] rsp_data,
    output logic req_valid,
    output fptr_pkg::fptr_space_t req_space,
    output logic [15:0] req_addr
);
    timeunit 1ns;
    timeprecision 1ps;
    import fptr_pkg::*;
    initial begin
        req_valid = 1'b0;
        req_space = FPTR_SPACE_LAT;
        req_addr = 16'h0000;
    end
    // Called at a falling edge; keeps the request up so reads run back to back
    task automatic rd(input fptr_space_t sp, input logic [15:0] a, output logic v, output logic h,
        output logic [7:0] d);
        req_valid = 1'b1;
        req_space = sp;
        req_addr = a;
        @(negedge clock);
        v = rsp_valid;
        h = rsp_hit;
        d = rsp_data;
    endtask
    // Drops the request; address no longer shows the last value
    task automatic idle();
        req_valid = 1'b0;
        req_addr = ~req_addr;
        @(negedge clock);
    endtask
endmodule

// ==== sim/testbench.sv ====
// Self-checking bench for the parameter table store
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import fptr_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic req_valid, rsp_valid, rsp_hit;
    fptr_space_t req_space;
    logic [15:0] req_addr;
    logic [7:0] rsp_data;
    int miscompares = 0;
    int num_checks = 0;
    localparam logic [7:0] JX [0:9] = '{8'ha5, 8'h50, 8'he7, 8'hff, 8'hea, 8'hff, 8'hff, 8'hff, 8'hff, 8'h3f};
    fptr_top fptr_top_i(.clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req_space(req_space),
        .req_addr(req_addr), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_data(rsp_data));
    fptr_host fptr_host_i(.clock(clock), .rsp_valid(rsp_valid), .rsp_hit(rsp_hit), .rsp_data(rsp_data),
        .req_valid(req_valid), .req_space(req_space), .req_addr(req_addr));
    initial begin
        forever #2 clock = ~clock;
    end
    // ==========================================================
    // Compare and read helpers
    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t byte %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk1(input logic got, input logic exp);
        num_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("BAD %0t flag %b expected %b", $time, got, exp);
        end
    endtask
    task automatic rx(input fptr_space_t sp, input logic [15:0] a, input logic eh, input logic [7:0] ed);
        logic v, h;
        logic [7:0] d;
        fptr_host_i.rd(sp, a, v, h, d);
        chk1(v, 1'b1);
        chk1(h, eh);
        chk8(d, ed);
    endtask
    task automatic complete_run();
        $display("checks %0d miscompares %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_lat();
        for (int i = 'h27; i <= 'h2b; i++) rx(FPTR_SPACE_LAT, 16'(i), 1'b1, 8'hff);
        rx(FPTR_SPACE_LAT, 16'h0026, 1'b0, 8'hff);
        rx(FPTR_SPACE_LAT, 16'h002c, 1'b0, 8'hff);
    endtask
    task automatic t_pad();
        rx(FPTR_SPACE_PAD, 16'h0000, 1'b1, 8'hf0);
        rx(FPTR_SPACE_PAD, 16'h0001, 1'b1, 8'h0f);
        for (int i = 2; i <= 'h10; i++) rx(FPTR_SPACE_PAD, 16'(i), 1'b1, 8'hff);
        rx(FPTR_SPACE_PAD, 16'h0001 + 16'h0001 + 16'h000f, 1'b0, 8'hff);
        rx(FPTR_SPACE_JEDEC, 16'h0000, 1'b1, 8'ha5);
    endtask
    task automatic t_jedec();
        for (int i = 0; i <= 9; i++) rx(FPTR_SPACE_JEDEC, 16'(i), 1'b1, JX[i]);
        rx(FPTR_SPACE_JEDEC, 16'h000a, 1'b0, 8'hff);
    endtask
    task automatic t_sfdp();
        for (int i = 0; i <= 7; i++) rx(FPTR_SPACE_SFDP, 16'h1120 + 16'(i), 1'b1, JX[i+2]);
        rx(FPTR_SPACE_SFDP, 16'h111f, 1'b0, 8'hff);
        rx(FPTR_SPACE_SFDP, 16'h1128, 1'b0, 8'hff);
    endtask
    task automatic t_idle_reset();
        rx(FPTR_SPACE_JEDEC, 16'h0009, 1'b1, 8'h3f);
        fptr_host_i.idle();
        chk1(rsp_valid, 1'b0);
        chk8(rsp_data, 8'h3f);
        reset_n = 1'b0;
        #1 chk1(rsp_valid, 1'b0);
        chk8(rsp_data, 8'hff);
        @(negedge clock);
        reset_n = 1'b1;
        rx(FPTR_SPACE_JEDEC, 16'h0002, 1'b1, 8'he7);
    endtask
    initial begin
        repeat (12) @(negedge clock);
        chk1(rsp_valid, 1'b0);
        chk8(rsp_data, 8'hff);
        reset_n = 1'b1;
        @(negedge clock);
        t_lat();
        t_pad();
        t_jedec();
        t_sfdp();
        t_idle_reset();
        fptr_host_i.idle();
        complete_run();
    end
    initial begin
        repeat (2000) @(posedge clock);
        miscompares++;
        complete_run();
    end
endmodule
